/* hdl/idfs_map.vh */
// Register offsets, field positions, reset values for the I2C control slice
// Included by the control block and its spike filter
`ifndef IDFS_MAP_VH
`define IDFS_MAP_VH
`define IDFS_OFS_CTRL 8'h00
`define IDFS_OFS_SETUP 8'h04
`define IDFS_CTRL_SPEED_LO 4
`define IDFS_CTRL_SPEED_HI 5
`define IDFS_CTRL_DMATX 9
`define IDFS_CTRL_DMARX 10
`define IDFS_CTRL_FILT_LO 13
`define IDFS_CTRL_FILT_HI 14
`define IDFS_CTRL_FSTOP 15
`define IDFS_SETUP_ALO_HI 6
`define IDFS_SETUP_AHI_LO 7
`define IDFS_SETUP_AHI_HI 9
`define IDFS_SETUP_SU_LO 16
`define IDFS_SETUP_SU_HI 31
`define IDFS_RST_ALO 7'h55
`define IDFS_RST_SU 16'h000f
`define IDFS_FILT_1 2'h1
`define IDFS_FILT_2 2'h2
`define IDFS_FILT_4 2'h3
`define IDFS_LIM_1 3'h1
`define IDFS_LIM_2 3'h2
`define IDFS_LIM_4 3'h4
`endif

/* hdl/idfs_spike_filter.v */
// Spike filter for one bus line: synchroniser plus selectable glitch width
// Assumes the pin is asynchronous to clk; idle level of the line is high
`timescale 1ns/1ps
`default_nettype none
`include "idfs_map.vh"
module idfs_spike_filter #(
   parameter CNT_W = 3
) (
   input wire clk,
   input wire srst,
   input wire pinIn,
   input wire [1:0] filtSel,
   output reg lineOut_ff
);
   reg s1_ff;
   reg s2_ff;
   reg s3_ff;
   reg [CNT_W-1:0] cnt_ff;
   reg [CNT_W-1:0] lim;
   reg [CNT_W-1:0] nxt_cnt;
   reg nxt_line;
   wire stable;
   assign stable = (s2_ff == s3_ff);
   always @* begin
      case (filtSel)
         `IDFS_FILT_1: lim = `IDFS_LIM_1;
         `IDFS_FILT_2: lim = `IDFS_LIM_2;
         `IDFS_FILT_4: lim = `IDFS_LIM_4;
         default: lim = 3'h0;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   // Level must persist longer than lim+1 cycles before it is accepted
   always @* begin
      nxt_cnt = cnt_ff;
      nxt_line = lineOut_ff;
      if (!stable || s2_ff == lineOut_ff) begin
         nxt_cnt = 3'h0;
      end else if (cnt_ff >= lim) begin
         nxt_line = s2_ff;
         nxt_cnt = 3'h0;
      end else begin
         nxt_cnt = cnt_ff + 3'h1;
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
         cnt_ff <= 3'h0;
         lineOut_ff <= 1'b1;
      end else begin
         s1_ff <= pinIn;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         cnt_ff <= nxt_cnt;
         lineOut_ff <= nxt_line;
      end
   end
endmodule // idfs_spike_filter
`default_nettype wire

/* hdl/idfs_ctrl.v */
// Control and own-address registers of an I2C node: DMA enables, filters,
// forced stop, own address and slave setup timing
// Assumes a simple strobe register port and a DMA end-of-transfer pulse on clk
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "idfs_map.vh"
module idfs_ctrl (
   input wire clk,
   input wire srst,
   input wire [7:0] regAddr,
   input wire [31:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [31:0] regRdata_ff,
   input wire txDataNeeded,
   input wire rxDataReady,
   input wire dmaEndOfTransfer,
   output wire dmaTxReq,
   output wire dmaRxReq,
   input wire sdaPin,
   input wire sclPin,
   output wire sdaFiltered,
   output wire sclFiltered,
   input wire stopDone,
   output wire forcedStopPending,
   input wire stretchRelease,
   output reg setupDone_ff,
   output wire [9:0] ownAddr,
   output wire [1:0] speedSelect
);
   reg [1:0] speed_ff;
   reg dmaTxEn_ff;
   reg dmaRxEn_ff;
   reg [1:0] filt_ff;
   reg fstop_ff;
   reg [6:0] aLo_ff;
   reg [2:0] aHi_ff;
   reg [15:0] setup_ff;
   reg [15:0] suCnt_ff;
   reg suRun_ff;
   // Next-state values
   reg [1:0] nxt_speed;
   reg nxt_dmaTxEn;
   reg nxt_dmaRxEn;
   reg [1:0] nxt_filt;
   reg nxt_fstop;
   reg [6:0] nxt_aLo;
   reg [2:0] nxt_aHi;
   reg [15:0] nxt_setup;
   reg [15:0] nxt_suCnt;
   reg nxt_suRun;
   reg nxt_setupDone;
   reg [31:0] nxt_rdata;
   // Register write decode
   wire wrCtrl;
   wire wrSetup;
   assign wrCtrl = regWr && (regAddr == `IDFS_OFS_CTRL);
   assign wrSetup = regWr && (regAddr == `IDFS_OFS_SETUP);
   assign dmaTxReq = dmaTxEn_ff && txDataNeeded;
   assign dmaRxReq = dmaRxEn_ff && rxDataReady;
   assign forcedStopPending = fstop_ff;
   assign ownAddr = {aHi_ff, aLo_ff};
   assign speedSelect = speed_ff;
   ////////////////////////////////////////////////////////////////////////////
   // Control register; end of transfer beats a same-cycle software write of the DMA enables
   always @* begin
      nxt_speed = speed_ff;
      nxt_dmaTxEn = dmaTxEn_ff;
      nxt_dmaRxEn = dmaRxEn_ff;
      nxt_filt = filt_ff;
      if (wrCtrl) begin
         nxt_speed = regWdata[`IDFS_CTRL_SPEED_HI:`IDFS_CTRL_SPEED_LO];
         nxt_dmaTxEn = regWdata[`IDFS_CTRL_DMATX];
         nxt_dmaRxEn = regWdata[`IDFS_CTRL_DMARX];
         nxt_filt = regWdata[`IDFS_CTRL_FILT_HI:`IDFS_CTRL_FILT_LO];
      end
      if (dmaEndOfTransfer) begin
         nxt_dmaTxEn = 1'h0;
         nxt_dmaRxEn = 1'h0;
      end
   end
   // Stop completion wins only when no new request arrives
   always @* begin
      nxt_fstop = fstop_ff;
      if (wrCtrl && regWdata[`IDFS_CTRL_FSTOP]) begin
         nxt_fstop = 1'h1;
      end else if (wrCtrl || stopDone) begin
         nxt_fstop = 1'h0;
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         speed_ff <= 2'h0;
         dmaTxEn_ff <= 1'h0;
         dmaRxEn_ff <= 1'h0;
         filt_ff <= 2'h0;
         fstop_ff <= 1'h0;
      end else begin
         speed_ff <= nxt_speed;
         dmaTxEn_ff <= nxt_dmaTxEn;
         dmaRxEn_ff <= nxt_dmaRxEn;
         filt_ff <= nxt_filt;
         fstop_ff <= nxt_fstop;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Own address and setup register
   always @* begin
      nxt_aLo = aLo_ff;
      nxt_aHi = aHi_ff;
      nxt_setup = setup_ff;
      if (wrSetup) begin
         nxt_aLo = regWdata[`IDFS_SETUP_ALO_HI:0];
         nxt_aHi = regWdata[`IDFS_SETUP_AHI_HI:`IDFS_SETUP_AHI_LO];
         nxt_setup = regWdata[`IDFS_SETUP_SU_HI:`IDFS_SETUP_SU_LO];
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         aLo_ff <= `IDFS_RST_ALO;
         aHi_ff <= 3'h0;
         setup_ff <= `IDFS_RST_SU;
      end else begin
         aLo_ff <= nxt_aLo;
         aHi_ff <= nxt_aHi;
         setup_ff <= nxt_setup;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Setup timer: pulse setup-1 cycles after stretch release
   always @* begin
      nxt_suCnt = suCnt_ff;
      nxt_suRun = suRun_ff;
      nxt_setupDone = 1'h0;
      if (stretchRelease) begin
         // A restart mid-count discards the old count
         if (setup_ff <= 16'h0001) begin
            nxt_setupDone = 1'h1;
            nxt_suRun = 1'h0;
         end else begin
            // Loaded two short: release and pulse edges both count
            nxt_suCnt = setup_ff - 16'h0002;
            nxt_suRun = 1'h1;
         end
      end else if (suRun_ff) begin
         if (suCnt_ff == 16'h0000) begin
            nxt_setupDone = 1'h1;
            nxt_suRun = 1'h0;
         end else begin
            nxt_suCnt = suCnt_ff - 16'h0001;
         end
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         suCnt_ff <= 16'h0000;
         suRun_ff <= 1'h0;
         setupDone_ff <= 1'h0;
      end else begin
         suCnt_ff <= nxt_suCnt;
         suRun_ff <= nxt_suRun;
         setupDone_ff <= nxt_setupDone;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Read port; unmapped and reserved bits read zero
   always @* begin
      nxt_rdata = regRdata_ff;
      if (regRd) begin
         nxt_rdata = 32'h00000000;
         if (regAddr == `IDFS_OFS_CTRL) begin
            nxt_rdata[`IDFS_CTRL_SPEED_HI:`IDFS_CTRL_SPEED_LO] = speed_ff;
            nxt_rdata[`IDFS_CTRL_DMATX] = dmaTxEn_ff;
            nxt_rdata[`IDFS_CTRL_DMARX] = dmaRxEn_ff;
            nxt_rdata[`IDFS_CTRL_FILT_HI:`IDFS_CTRL_FILT_LO] = filt_ff;
            nxt_rdata[`IDFS_CTRL_FSTOP] = fstop_ff;
         end else if (regAddr == `IDFS_OFS_SETUP) begin
            nxt_rdata[`IDFS_SETUP_ALO_HI:0] = aLo_ff;
            nxt_rdata[`IDFS_SETUP_AHI_HI:`IDFS_SETUP_AHI_LO] = aHi_ff;
            nxt_rdata[`IDFS_SETUP_SU_HI:`IDFS_SETUP_SU_LO] = setup_ff;
         end
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         regRdata_ff <= 32'h00000000;
      end else begin
         regRdata_ff <= nxt_rdata;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Line filters
   idfs_spike_filter #(.CNT_W(3)) uSdaFilt (
      .clk(clk),
      .srst(srst),
      .pinIn(sdaPin),
      .filtSel(filt_ff),
      .lineOut_ff(sdaFiltered)
   );
   idfs_spike_filter #(.CNT_W(3)) uSclFilt (
      .clk(clk),
      .srst(srst),
      .pinIn(sclPin),
      .filtSel(filt_ff),
      .lineOut_ff(sclFiltered)
   );
endmodule // idfs_ctrl
`default_nettype wire

/* tb/idfs_ctrl_properties.sv */
// Port checker for idfs_ctrl
// Bound to every idfs_ctrl instance; ports share names
`timescale 1ns/1ps
`default_nettype none
module idfs_ctrl_chk (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdata_ff,
   input wire logic txDataNeeded,
   input wire logic rxDataReady,
   input wire logic dmaEndOfTransfer,
   input wire logic dmaTxReq,
   input wire logic dmaRxReq,
   input wire logic sdaPin,
   input wire logic sdaFiltered,
   input wire logic forcedStopPending,
   input wire logic stretchRelease,
   input wire logic setupDone_ff,
   input wire logic [9:0] ownAddr
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic [15:0] su_ff, cnt_ff;
   wire [15:0] ex = (su_ff < 16'h0002) ? 16'h0001 : su_ff;
   wire [9:0] wAddr = regWdata[9:0];
   // Cycles since the last stretch release, counting up to ex and then back to zero
   always @(posedge clk) begin
      if (srst) begin
         su_ff <= 16'h000f;
         cnt_ff <= 16'h0000;
      end else begin
         if (regWr && regAddr == 8'h04) su_ff <= regWdata[31:16];
         cnt_ff <= stretchRelease ? 16'h0001 :
            (cnt_ff != 16'h0000 && cnt_ff < ex) ? cnt_ff + 16'h0001 : 16'h0000;
      end
   end
   sequence s_cw; regWr && regAddr == 8'h00 && !dmaEndOfTransfer; endsequence
   property p_tx; s_cw ##0 !regWdata[9] |=> !dmaTxReq; endproperty
   a_tx: assert property (p_tx) else $error("tx request while off");
   property p_rx; s_cw ##0 regWdata[10] |=> dmaRxReq == rxDataReady; endproperty
   a_rx: assert property (p_rx) else $error("rx request wrong");
   property p_eot; dmaEndOfTransfer |=> !dmaTxReq && !dmaRxReq; endproperty
   a_eot: assert property (p_eot) else $error("dma not stopped");
   property p_stop; s_cw ##0 regWdata[15] |=> forcedStopPending; endproperty
   a_stop: assert property (p_stop) else $error("stop not pending");
   property p_addr; regWr && regAddr == 8'h04 |=> ownAddr == $past(wAddr); endproperty
   a_addr: assert property (p_addr) else $error("own address wrong");
   property p_rsv; regRd && regAddr == 8'h04 |=> regRdata_ff[15:10] == 6'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_su; setupDone_ff == (cnt_ff == ex); endproperty
   a_su: assert property (p_su) else $error("setup pulse misplaced");
   property p_flt; $changed(sdaFiltered) |-> $past(sdaPin, 3) == sdaFiltered; endproperty
   a_flt: assert property (p_flt) else $error("filter output unfounded");
endmodule // idfs_ctrl_chk
bind idfs_ctrl idfs_ctrl_chk i_idfs_ctrl_chk (.*);
`default_nettype wire

/* tb/idfs_dma_model.sv */
// DMA controller stand-in: ends a transfer after LEN requests
// Assumes level requests sampled on clk
`timescale 1ns/1ps
`default_nettype none
module idfs_dma_model #(
   parameter int LEN = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic req,
   output logic eot_ff
);
   int n_ff;
   always @(posedge clk) begin
      if (srst) begin
         n_ff <= 0;
         eot_ff <= 1'h0;
      end else begin
         eot_ff <= req && !eot_ff && n_ff == LEN - 1;
         if (req && !eot_ff) n_ff <= (n_ff == LEN - 1) ? 0 : n_ff + 1;
      end
   end
endmodule // idfs_dma_model
`default_nettype wire

/* tb/idfs_ctrl_test.sv */
// Self-checking bench for idfs_ctrl
// Pins sda and scl share one driver; DMA model answers requests
`timescale 1ns/1ps
`default_nettype none
module idfs_ctrl_test;
   logic clk = 1'h0, srst = 1'h1, regWr = 1'h0, regRd = 1'h0, pin = 1'h1, sd = 1'h0, rel = 1'h0;
   logic txNeed = 1'h1, rxRdy = 1'h1;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic [1:0] seen;
   wire logic eot, txReq, rxReq, sdaF, sclF, stopPend, suDone;
   wire logic [9:0] ownAddr;
   wire logic [1:0] speed;
   wire logic [31:0] rdata;
   int errCount = 0, comparisons = 0, cyc = 0, k, i;
   int sel[5] = '{0, 1, 2, 3, 3}, w[5] = '{2, 1, 2, 4, 12}, lo[5] = '{3, 0, 0, 0, 3};
   int en[3] = '{'h200, 'h400, 0};
   idfs_ctrl i_idfs_ctrl (.clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata_ff(rdata), .txDataNeeded(txNeed),
      .rxDataReady(rxRdy), .dmaEndOfTransfer(eot), .dmaTxReq(txReq), .dmaRxReq(rxReq),
      .sdaPin(pin), .sclPin(pin), .sdaFiltered(sdaF), .sclFiltered(sclF), .stopDone(sd),
      .forcedStopPending(stopPend), .stretchRelease(rel), .setupDone_ff(suDone),
      .ownAddr(ownAddr), .speedSelect(speed));
   idfs_dma_model #(.LEN(4)) i_idfs_dma_model (.clk(clk), .srst(srst), .req(txReq | rxReq),
      .eot_ff(eot));
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errCount++;
         finalReport();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errCount++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'h1;
      @(posedge clk);
      regWr <= 1'h0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'h1;
      @(posedge clk);
      regRd <= 1'h0;
      #1 chk("read", exp, rdata);
   endtask
   task automatic su_chk(input logic [15:0] su);
      wr(8'h04, {su, 16'h0055});
      @(posedge clk) rel <= 1'h1;
      @(posedge clk) rel <= 1'h0;
      k = 0;
      do begin
         @(posedge clk);
         #1 k++;
      end while (suDone !== 1'h1 && k < 40);
      chk("setup wait", {16'h0, su - 16'h1}, k);
   endtask
   task finalReport;
      $display("comparisons %0d mismatches %0d", comparisons, errCount);
      if (errCount == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'h0;
      rdc(8'h04, 32'h000f0055);
      rdc(8'h00, 32'h0);
      wr(8'h00, 32'hfffff830);
      rdc(8'h00, 32'h0000e030);
      chk("speed", 32'h3, {30'h0, speed});
      chk("stop", 32'h1, {31'h0, stopPend});
      @(posedge clk) sd <= 1'h1;
      @(posedge clk) sd <= 1'h0;
      #1 chk("stop", 32'h0, {31'h0, stopPend});
      wr(8'h04, 32'hffffffff);
      rdc(8'h04, 32'hffff03ff);
      chk("addr", 32'h3ff, {22'h0, ownAddr});
      rdc(8'h08, 32'h0);
      $display("test registers done");
      su_chk(16'h0005);
      su_chk(16'h0003);
      $display("test setup done");
      for (i = 0; i < 5; i++) begin
         wr(8'h00, sel[i] << 13);
         @(posedge clk) pin <= 1'h0;
         repeat (w[i]) @(posedge clk);
         pin <= 1'h1;
         seen = 2'h0;
         repeat (14) begin
            @(posedge clk);
            #1 seen = seen | ~{sdaF, sclF};
         end
         chk("filter", lo[i], {30'h0, seen});
      end
      $display("test filter done");
      for (i = 0; i < 3; i++) begin
         wr(8'h00, en[i]);
         k = 0;
         repeat (12) begin
            #1 k += (txReq | rxReq);
            @(posedge clk);
         end
         chk("dma cycles", (en[i] != 0) ? 5 : 0, k);
         rdc(8'h00, 32'h0);
      end
      $display("test dma done");
      finalReport();
   end
endmodule // idfs_ctrl_test
`default_nettype wire
